//--- src/clb_pkg.sv
// Shared constants of the chip link bring-up and flow-control block.
package clb_pkg;
  localparam int NUM_LANES  = 12;
  localparam int LANE_W     = 64;
  localparam int NUM_CH     = 16;
  localparam int DATA_W     = 32;
  localparam int CHAN_W     = 8;
  localparam int FIFO_DEPTH = 16;
  // Lane word layout; bit 63 is the first bit on the wire.
  localparam int HDR_HI   = 63;
  localparam int HDR_LO   = 62;
  localparam int CTYPE_HI = 61;
  localparam int CTYPE_LO = 56;
  localparam int FC_LO    = 0;
  localparam int SOP_BIT  = 61;
  localparam int EOP_BIT  = 60;
  localparam int CHAN_HI  = 55;
  localparam int CHAN_LO  = 48;
  localparam int PAY_HI   = 31;
  localparam int PAY_LO   = 0;
  localparam logic [1:0] HDR_CTRL    = 2'h2;
  localparam logic [1:0] HDR_DATA    = 2'h1;
  localparam logic [5:0] CTYPE_IDLE  = 6'h1e;
  localparam logic [2:0] ALIGN_COUNT = 3'h4;
endpackage

//--- src/clb_fifo.sv
// Transmit packet buffer with a registered read stage.
module clb_fifo #(
  parameter int W     = 42,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wrPtr;
    logic [PW-1:0]           rdPtr;
    logic [CW-1:0]           count;
    logic                    outValid;
    logic [W-1:0]            outData;
  } clb_fifo_s;

  clb_fifo_s s;
  clb_fifo_s next_s;

  // The output stage counts apart from the memory, so DEPTH words fit plus one held.
  assign inReady  = (s.count != CW'(DEPTH));
  assign outValid = s.outValid;
  assign outData  = s.outData;

  always_comb begin
    next_s = s;
    if (!s.outValid || outReady) begin
      if (s.count != '0) begin
        next_s.outValid = 1'b1;
        next_s.outData  = s.mem[s.rdPtr];
        next_s.rdPtr    = PW'(s.rdPtr + 1'b1);
        next_s.count    = CW'(next_s.count - 1'b1);
      end else begin
        next_s.outValid = 1'b0;
      end
    end
    if (inValid && inReady) begin
      next_s.mem[s.wrPtr] = inData;
      next_s.wrPtr        = PW'(s.wrPtr + 1'b1);
      next_s.count        = CW'(next_s.count + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

//--- src/clb_link.sv
// Multi-lane link core: bring-up, lane alignment, flow control and packet path.
// Notes on behaviour
// - After reset every idle transmit lane sends control idle words continuously.
// - Received control idle words drive each lane's synchronisation and the alignment.
// - An alignment output rises once every receive lane is locked.
// - Remote XON status is reported per channel on a flow-control output.
// - Flow-control status is pulled from incoming idle words without user help.
// - Transmit is one pipeline into one buffer, with no channel scheduling.
// - Packets enter on the transmit packet bus and leave on the receive one.
// - The core alone handles link words, synchronisation and header checking.
// - In each received lane word bit 63 is earliest and bit 0 latest.
// - Each receive lane is sampled on the timing of its own recovered clock.
// - In each transmitted lane word bit 63 goes first and bit 0 last.

module clb_link #(
  parameter int NL  = clb_pkg::NUM_LANES,
  parameter int NCH = clb_pkg::NUM_CH,
  parameter int FD  = clb_pkg::FIFO_DEPTH
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic [NL-1:0]                 rxLaneClk,
  input  wire logic [NL-1:0][63:0]           rxLaneData,
  output logic      [NL-1:0][63:0]           txLaneData,
  input  wire logic                          txValid,
  output logic                               txReady,
  input  wire logic [clb_pkg::DATA_W-1:0]    txData,
  input  wire logic                          txSop,
  input  wire logic                          txEop,
  input  wire logic [clb_pkg::CHAN_W-1:0]    txChan,
  input  wire logic [NCH-1:0]                xonLocal,
  output logic      [NCH-1:0]                remoteXon,
  output logic                               rxAligned,
  output logic      [NL-1:0]                 laneLocked,
  output logic                               rxValid,
  output logic      [clb_pkg::DATA_W-1:0]    rxData,
  output logic                               rxSop,
  output logic                               rxEop,
  output logic      [clb_pkg::CHAN_W-1:0]    rxChan
);
  localparam int FW  = clb_pkg::DATA_W + clb_pkg::CHAN_W + 2;
  // The lane pointer is sized from the lane count, so NL must be two or more.
  localparam int LPW = $clog2(NL);

  // Lane words cross by sampling a word that stands still for half a lane clock, which
  // costs two wide registers per lane but needs no per-lane buffer.
  typedef struct packed {
    logic [NL-1:0]                 clkSync1;
    logic [NL-1:0]                 clkSync2;
    logic [NL-1:0]                 clkPrev;
    logic [NL-1:0][63:0]           dataSync1;
    logic [NL-1:0][63:0]           dataSync2;
    logic [NL-1:0][2:0]            lockCnt;
    logic [NL-1:0]                 locked;
    logic [NL-1:0]                 pend;
    logic [NL-1:0][63:0]           pendWord;
    logic [NL-1:0][63:0]           txLane;
    logic [LPW-1:0]                lanePtr;
    logic [NCH-1:0]                remoteXon;
    logic                          aligned;
    logic                          rxValid;
    logic [clb_pkg::DATA_W-1:0]    rxData;
    logic                          rxSop;
    logic                          rxEop;
    logic [clb_pkg::CHAN_W-1:0]    rxChan;
  } clb_link_s;

  clb_link_s          s;
  clb_link_s          next_s;
  logic               fifoOutValid;
  logic               fifoOutReady;
  logic [FW-1:0]      fifoOutData;

  // Header decoding stays in one place for every lane.
  function automatic logic isCtrl(input logic [63:0] w);
    return w[clb_pkg::HDR_HI:clb_pkg::HDR_LO] == clb_pkg::HDR_CTRL;
  endfunction

  function automatic logic isData(input logic [63:0] w);
    return w[clb_pkg::HDR_HI:clb_pkg::HDR_LO] == clb_pkg::HDR_DATA;
  endfunction

  // The single transmit buffer; back-pressure reaches the user as txReady.
  clb_fifo #(
    .W     (FW),
    .DEPTH (FD)
  ) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (txValid),
    .inReady  (txReady),
    .inData   ({txSop, txEop, txChan, txData}),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // Payload is held in the buffer until the link has aligned.
  assign fifoOutReady = s.aligned;

  assign txLaneData = s.txLane;
  assign remoteXon  = s.remoteXon;
  assign rxAligned  = s.aligned;
  assign laneLocked = s.locked;
  assign rxValid    = s.rxValid;
  assign rxData     = s.rxData;
  assign rxSop      = s.rxSop;
  assign rxEop      = s.rxEop;
  assign rxChan     = s.rxChan;

  always_comb begin
    logic [63:0] idleWord;
    logic [63:0] dataWord;
    logic [63:0] w;
    logic        found;
    idleWord = '0;
    dataWord = '0;
    w        = '0;
    found    = 1'b0;
    next_s   = s;

    // Lane clocks and data pass two flip-flops before anything reads them.
    next_s.clkSync1  = rxLaneClk;
    next_s.clkSync2  = s.clkSync1;
    next_s.clkPrev   = s.clkSync2;
    next_s.dataSync1 = rxLaneData;
    next_s.dataSync2 = s.dataSync1;

    // Header goes in the top bits so it leaves the lane first.
    idleWord[clb_pkg::HDR_HI:clb_pkg::HDR_LO]     = clb_pkg::HDR_CTRL;
    idleWord[clb_pkg::CTYPE_HI:clb_pkg::CTYPE_LO] = clb_pkg::CTYPE_IDLE;
    idleWord[clb_pkg::FC_LO +: NCH]               = xonLocal;
    dataWord[clb_pkg::HDR_HI:clb_pkg::HDR_LO]     = clb_pkg::HDR_DATA;
    dataWord[clb_pkg::SOP_BIT]                    = fifoOutData[FW-1];
    dataWord[clb_pkg::EOP_BIT]                    = fifoOutData[FW-2];
    dataWord[clb_pkg::CHAN_HI:clb_pkg::CHAN_LO]   = fifoOutData[FW-3 -: clb_pkg::CHAN_W];
    dataWord[clb_pkg::PAY_HI:clb_pkg::PAY_LO]     = fifoOutData[clb_pkg::DATA_W-1:0];

    // Every lane falls back to idle, so the far end keeps its lock between data words.
    for (int i = 0; i < NL; i++) begin
      next_s.txLane[i] = idleWord;
    end

    // Words go to the lanes in turn; the receive side takes pending words lowest lane first, not in turn.
    if (s.aligned && fifoOutValid) begin
      next_s.txLane[s.lanePtr] = dataWord;
      if (s.lanePtr == LPW'(NL - 1)) begin
        next_s.lanePtr = '0;
      end else begin
        next_s.lanePtr = LPW'(s.lanePtr + 1'b1);
      end
    end

    // One received word per cycle leaves, lowest lane first.
    next_s.rxValid = 1'b0;
    for (int i = 0; i < NL; i++) begin
      if (s.pend[i] && !found) begin
        found          = 1'b1;
        next_s.pend[i] = 1'b0;
        next_s.rxValid = 1'b1;
        next_s.rxData  = s.pendWord[i][clb_pkg::PAY_HI:clb_pkg::PAY_LO];
        next_s.rxSop   = s.pendWord[i][clb_pkg::SOP_BIT];
        next_s.rxEop   = s.pendWord[i][clb_pkg::EOP_BIT];
        next_s.rxChan  = s.pendWord[i][clb_pkg::CHAN_HI:clb_pkg::CHAN_LO];
      end
    end

    // Words are taken on the falling edge of each lane clock, half a period after the
    // rising edge, when the lane data has long settled. The lane clock must be at least
    // four core cycles long for this to hold.
    for (int i = 0; i < NL; i++) begin
      if (s.clkPrev[i] && !s.clkSync2[i]) begin
        w = s.dataSync2[i];

        if (isCtrl(w)) begin
          if (s.lockCnt[i] != clb_pkg::ALIGN_COUNT) begin
            next_s.lockCnt[i] = 3'(s.lockCnt[i] + 1'b1);
          end else begin
            next_s.locked[i] = 1'b1;
          end

          if (i == 0 && s.aligned &&
              w[clb_pkg::CTYPE_HI:clb_pkg::CTYPE_LO] == clb_pkg::CTYPE_IDLE) begin
            next_s.remoteXon = w[clb_pkg::FC_LO +: NCH];
          end
        end else if (isData(w)) begin
          // A word still waiting on this lane is lost, so lanes must not outrun the port.
          if (s.locked[i]) begin
            // A new word wins over the clear made above in the same cycle.
            next_s.pend[i]     = 1'b1;
            next_s.pendWord[i] = w;
          end
        end else begin
          // A bad header drops the lock of this lane only.
          next_s.lockCnt[i] = '0;
          next_s.locked[i]  = 1'b0;
        end
      end
    end

    // Alignment follows this cycle's locks, so a lost lane stops data at once.
    next_s.aligned = &next_s.locked;
    // Stale remote XON would report the far end ready on a link that is down.
    if (!next_s.aligned) begin
      next_s.remoteXon = '0;
    end
  end

  // The whole state resets as one struct, so no field can be missed.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

//--- bench/clb_link_asserts.sv
// Port-level checks of the link core, bound into every instance of it.
module clb_link_asserts #(
  parameter int NL  = 12,
  parameter int NCH = 16
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic [NL-1:0][63:0] txLaneData,
  input wire logic                txValid,
  input wire logic                txReady,
  input wire logic [NCH-1:0]      xonLocal,
  input wire logic [NCH-1:0]      remoteXon,
  input wire logic                rxAligned,
  input wire logic [NL-1:0]       laneLocked,
  input wire logic                rxValid
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence sDown3;
    !rxAligned [*3];
  endsequence
  sequence sIdle0;
    txLaneData[0][63:56] == {clb_pkg::HDR_CTRL, clb_pkg::CTYPE_IDLE};
  endsequence
  // The first sample after release still shows reset values, hence the past guard.
  AST_HDR_OK: assert property ($past(rst_n) |-> txLaneData[0][63:62] inside {2'h1, 2'h2})
    else $error("transmit lane header invalid");
  AST_IDLE_DOWN: assert property (sDown3 |-> sIdle0)
    else $error("lane sends no idle while unaligned");
  AST_XON_COPY: assert property (txLaneData[1][63:62] == clb_pkg::HDR_CTRL |->
    txLaneData[1][15:0] == $past(xonLocal[15:0])) else $error("idle word xon stale");
  AST_ALIGN_ALL: assert property (rxAligned == &laneLocked)
    else $error("aligned flag disagrees with lane locks");
  AST_XON_GATE: assert property (!rxAligned && !$past(rxAligned) |-> remoteXon == '0)
    else $error("remote xon shown while unaligned");
  AST_RX_LOCKED: assert property (rxValid |-> (|laneLocked) || $past(|laneLocked))
    else $error("receive word without locked lane");
  AST_READY_FALL: assert property ($fell(txReady) |-> $past(txValid))
    else $error("ready fell without a write");
  AST_LOCK_TIME: assert property ($rose(laneLocked[0]) |-> !$past(laneLocked[0], 16))
    else $error("lane locked too fast");
endmodule
bind clb_link clb_link_asserts #(.NL(NL), .NCH(NCH)) u_asserts (.clk, .rst_n, .txLaneData,
  .txValid, .txReady, .xonLocal, .remoteXon, .rxAligned, .laneLocked, .rxValid);

//--- bench/clb_remote_model.sv
// Remote link device: free-running lane clocks and the lane words it sends.
module clb_remote_model (
  input  wire logic              goData,
  input  wire logic              badHdr,
  input  wire logic [15:0]       xonRemote,
  output logic      [11:0]       laneClk,
  output logic      [11:0][63:0] laneData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] seq = 32'h0;
  // Half-nanosecond offsets keep every lane edge away from the core clock edges.
  for (genvar i = 0; i < 12; i++) begin : g_lane
    initial begin
      laneClk[i] = 1'b0;
      #(i * 5.0 + 3.5);
      forever #32 laneClk[i] = ~laneClk[i];
    end
    always @(posedge laneClk[i]) begin
      if (badHdr && i == 3) begin
        laneData[i] <= {2'h3, 62'h0};
      end else if (goData && i == 5) begin
        laneData[i] <= {clb_pkg::HDR_DATA, 2'h3, 4'h0, 8'h5a, 16'h0, seq};
      end else begin
        laneData[i] <= {clb_pkg::HDR_CTRL, clb_pkg::CTYPE_IDLE, 40'h0, xonRemote};
      end
    end
  end
  // The payload counter has one driver, stepped with each data word of lane 5 while badHdr is low.
  always @(posedge laneClk[5]) begin
    if (goData && !badHdr) begin
      seq <= seq + 32'h1;
    end
  end
endmodule

//--- bench/tb_top.sv
// Self-checking bench of the link core against the remote device model.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk;
  logic              rst_n = 1'b0;
  logic [11:0]       laneClk;
  logic [11:0][63:0] laneData;
  logic [11:0][63:0] txLaneData;
  logic              txValid = 1'b0;
  logic              txReady;
  logic [31:0]       txData = 32'h0;
  logic [15:0]       xonLocal = 16'h0;
  logic [15:0]       remoteXon;
  logic              rxAligned;
  logic [11:0]       laneLocked;
  logic              rxValid;
  logic [31:0]       rxData;
  logic              rxSop;
  logic              rxEop;
  logic [7:0]        rxChan;
  logic              goData = 1'b0;
  logic              badHdr = 1'b0;
  int                mismatches = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  clb_link dut (.clk, .rst_n, .rxLaneClk(laneClk), .rxLaneData(laneData), .txLaneData, .txValid,
    .txReady, .txData, .txSop(txData[0]), .txEop(txData[1]), .txChan(txData[7:0]), .xonLocal,
    .remoteXon, .rxAligned, .laneLocked, .rxValid, .rxData, .rxSop, .rxEop, .rxChan);
  clb_remote_model remote (.goData, .badHdr, .xonRemote(16'h3c81), .laneClk, .laneData);
  function automatic logic [63:0] idle(logic [15:0] x);
    return {clb_pkg::HDR_CTRL, clb_pkg::CTYPE_IDLE, 40'h0, x};
  endfunction
  function automatic logic [63:0] dword(logic [31:0] d);
    return {clb_pkg::HDR_DATA, d[0], d[1], 4'h0, d[7:0], 16'h0, d};
  endfunction
  task automatic chk(string n, logic [63:0] s, logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // A refused word is withdrawn after a bounded wait, so a full buffer cannot hang us.
  task automatic send(logic [31:0] d, output bit ok);
    int n;
    n = 0;
    @(posedge clk) txValid <= 1'b1;
    txData <= d;
    @(negedge clk);
    while (txReady !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    ok = (txReady === 1'b1);
    @(posedge clk) txValid <= 1'b0;
  endtask
  task automatic t_boot;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 12; i++) chk("txIdle", txLaneData[i], idle(16'h0));
  endtask
  task automatic t_align;
    int n;
    n = 0;
    while (rxAligned !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("laneLocked", laneLocked, 12'hfff);
    chk("rxAligned", rxAligned, 1'b1);
    repeat (40) @(negedge clk);
    chk("remoteXon", remoteXon, 16'h3c81);
    @(posedge clk) xonLocal <= 16'h00a5;
    repeat (3) @(negedge clk);
    chk("txXon", txLaneData[11], idle(16'h00a5));
  endtask
  task automatic t_tx;
    bit ok;
    int n;
    send(32'hcafe0007, ok);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (txLaneData[0][63:62] !== 2'h1 && n < 10);
    chk("txWord", txLaneData[0], dword(32'hcafe0007));
  endtask
  task automatic t_fill;
    bit ok;
    int k;
    int n;
    @(posedge clk) badHdr <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rxAligned !== 1'b0 && n < 100);
    chk("lane3", laneLocked[3], 1'b0);
    chk("alignDown", rxAligned, 1'b0);
    chk("xonDown", remoteXon, 16'h0);
    k = 0;
    ok = 1'b1;
    while (ok && k < 20) begin
      send(32'h07 + (k << 8), ok);
      k += ok;
    end
    chk("accepted", k, 17);
    @(posedge clk) badHdr <= 1'b0;
    k = 0;
    repeat (600) begin
      @(negedge clk);
      for (int i = 0; i < 12; i++) begin
        if (txLaneData[i][63:62] === 2'h1) begin
          chk("drain", txLaneData[i], dword(32'h07 + (k << 8)));
          chk("drainLane", i, (k + 1) % 12);
          k++;
        end
      end
    end
    chk("drained", k, 17);
    chk("xonBack", remoteXon, 16'h3c81);
  endtask
  task automatic t_rx;
    int k;
    k = 0;
    @(posedge clk) goData <= 1'b1;
    for (int c = 0; c < 160; c++) begin
      if (c == 100) @(posedge clk) goData <= 1'b0;
      @(negedge clk);
      if (rxValid === 1'b1) begin
        chk("rxData", rxData, k);
        chk("rxFields", {rxSop, rxEop, rxChan}, 10'h35a);
        k++;
      end
    end
    chk("rxCount", k > 9, 1'b1);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_boot();
    t_align();
    t_tx();
    t_fill();
    t_rx();
    print_verdict();
  end
endmodule
